// [shared/isp_pkg.sv]
// constants and types for the serial programming slave
package isp_pkg;
    localparam logic [7:0] OP_PROG = 8'hAC;
    localparam logic [7:0] SUB_ENABLE = 8'h53;
    localparam logic [7:0] SUB_ERASE = 8'h80;
    localparam logic [7:0] SUB_LOCK = 8'hE0;
    localparam logic [7:0] SUB_FUSE_LO = 8'hA0;
    localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
    localparam logic [7:0] SUB_FUSE_EXT = 8'hA4;
    localparam logic [7:0] OP_POLL = 8'hF0;
    localparam logic [7:0] OP_LD_EXT = 8'h4D;
    localparam logic [7:0] OP_LD_HI = 8'h48;
    localparam logic [7:0] OP_LD_LO = 8'h40;
    localparam logic [7:0] OP_LD_EE = 8'hC1;
    localparam logic [7:0] OP_RD_HI = 8'h28;
    localparam logic [7:0] OP_RD_LO = 8'h20;
    localparam logic [7:0] OP_RD_EE = 8'hA0;
    localparam logic [7:0] OP_RD_LOCK = 8'h58;
    localparam logic [7:0] OP_RD_SIG = 8'h30;
    localparam logic [7:0] OP_RD_FUSE = 8'h50;
    localparam logic [7:0] OP_RD_CAL = 8'h38;
    localparam logic [7:0] SUB_HI_SEL = 8'h08;
    localparam logic [7:0] OP_WR_PAGE = 8'h4C;
    localparam logic [7:0] OP_WR_EE = 8'hC0;
    localparam logic [7:0] OP_WR_EE_PG = 8'hC2;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int PAGE_BITS = 7;
    localparam int EE_BITS = 10;
    localparam int EE_PG_BITS = 2;
    localparam int CLK_MHZ = 125;
    localparam int FLASH_WAIT_US = 4500;
    localparam int EE_WAIT_US = 9000;
    localparam int ERASE_WAIT_US = 9000;
    localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
    localparam int EE_WAIT_CYC = EE_WAIT_US * CLK_MHZ;
    localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } instr_t;
    typedef struct packed {
        logic [7:0] lock;
        logic [7:0] fuse_lo;
        logic [7:0] fuse_hi;
        logic [7:0] fuse_ext;
    } fuses_t;
endpackage : isp_pkg

// [hw/isp_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
module isp_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic clk,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end
endmodule : isp_sync

// [hw/isp_link.sv]
// link-clock shifter: samples input on rise, drives output on fall
`timescale 1ns/1ps
module isp_link (
    // link
    input wire logic sck,
    input wire logic link_rst,
    input wire logic mosi,
    output logic miso,
    // to core domain
    output logic [31:0] frame,
    output logic frame_tgl,
    output logic echo_tgl,
    output logic [7:0] echo_byte,
    // from core domain, stable during byte four
    input wire logic [7:0] rd_byte
);
    logic [4:0] cnt;
    logic [31:0] sh;
    logic [7:0] tx;
    logic [31:0] next_sh;
    assign next_sh = {sh[30:0], mosi};
    // msb-first shift, four bytes back to back
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            cnt <= 5'h00;
            sh <= 32'h0000_0000;
            frame <= 32'h0000_0000;
            frame_tgl <= 1'b0;
            echo_tgl <= 1'b0;
            echo_byte <= 8'h00;
        end else begin
            sh <= next_sh;
            cnt <= cnt + 5'h01;
            if (cnt == 5'h0F) begin
                echo_byte <= next_sh[7:0];
            end
            // first three bytes in: core stages byte four from them
            if (cnt == 5'h17) begin
                frame <= {8'h00, next_sh[23:0]};
                echo_tgl <= ~echo_tgl;
            end
            if (cnt == 5'h1F) begin
                frame <= next_sh;
                frame_tgl <= ~frame_tgl;
            end
        end
    end
    // output shifted on falling edge
    always_ff @(negedge sck or posedge link_rst) begin
        if (link_rst) begin
            tx <= 8'h00;
        end else if (cnt == 5'h10) begin
            tx <= echo_byte;
        end else if (cnt == 5'h18) begin
            tx <= rd_byte;
        end else begin
            tx <= {tx[6:0], 1'b0};
        end
    end
    assign miso = tx[7];
endmodule : isp_link

// [hw/isp_core.sv]
// serial in-system programming slave, core domain
`timescale 1ns/1ps
// Functional notes
// - programming works only while reset pin is low, over sck, mosi, miso.
// - program and erase rejected until programming enable is executed.
// - each eeprom write erases the location first, no chip erase needed.
// - chip erase sets all flash and eeprom bytes to ff.
// - mosi sampled on rising sck edge.
// - miso driven on falling sck edge.
// - second enable byte echoed during third byte when in sync.
// - flash page buffer loaded bytewise by 7-bit word address, low then high.
// - extended address byte kept until reloaded.
// - eeprom byte written by one instruction with 10-bit address.
// - read returns addressed byte in byte four; flash uses extended address.
// - busy poll returns lsb one while programming pending.
// - load opcodes 4d, 48, 40, c1.
// - read opcodes for lock, fuses, signature and calibration.
// - write opcodes 4c, c2, and ac with e0, a0, a8, a4.
// - fuse and lock bits: zero programmed, one unprogrammed.
// - program memory addresses are word addresses within the page.
// - eeprom page bytes loaded to buffer, then committed.
module isp_core
    import isp_pkg::*;
#(
    parameter int FLASH_AW = 16,
    parameter int FLASH_WAIT = FLASH_WAIT_CYC,
    parameter int EE_WAIT = EE_WAIT_CYC,
    parameter int ERASE_WAIT = ERASE_WAIT_CYC,
    parameter logic [7:0] SIG0 = 8'h1E,  // arbitrary
    parameter logic [7:0] SIG1 = 8'h55,  // arbitrary
    parameter logic [7:0] SIG2 = 8'hA5,  // arbitrary
    parameter logic [7:0] CAL = 8'h80
) (
    // system
    input wire logic clk,
    input wire logic srst,
    // programming pins
    input wire logic reset_n_pin,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // status
    output logic prog_enabled,
    output logic pending_operation_flag,
    output isp_pkg::fuses_t fuses
);
    import isp_pkg::*;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FLASH = 2'b01,
        ST_EE = 2'b10,
        ST_ERASE = 2'b11
    } op_t;

    logic [7:0] flash_lo [0:(1<<FLASH_AW)-1];
    logic [7:0] flash_hi [0:(1<<FLASH_AW)-1];
    logic [7:0] eeprom [0:(1<<EE_BITS)-1];
    logic [7:0] buf_lo [0:(1<<PAGE_BITS)-1];
    logic [7:0] buf_hi [0:(1<<PAGE_BITS)-1];
    logic [7:0] ee_buf [0:(1<<EE_PG_BITS)-1];

    logic in_prog;
    logic [31:0] frame;
    logic frame_tgl;
    logic echo_tgl;
    logic [7:0] echo_byte;
    logic [7:0] rd_byte;
    logic [2:0] tgl_s;
    logic [2:0] tgl_d;
    logic [1:0] tgl_q;
    logic frame_evt;
    logic echo_evt;
    instr_t ins;
    logic [7:0] ext_adr;
    op_t op;
    logic [31:0] wait_cnt;
    logic [FLASH_AW-1:0] op_adr;
    logic [EE_BITS-1:0] ee_adr;
    logic ee_page;
    logic erase_busy;
    logic [FLASH_AW:0] erase_idx;
    logic [PAGE_BITS:0] copy_idx;

    // device programs only while reset pin is low
    isp_sync #(.W(1)) u_rst_sync (
        .clk(clk),
        .d(~reset_n_pin),
        .q(in_prog)
    );
    isp_link u_link (
        .sck(sck),
        .link_rst(reset_n_pin),
        .mosi(mosi),
        .miso(miso),
        .frame(frame),
        .frame_tgl(frame_tgl),
        .echo_tgl(echo_tgl),
        .echo_byte(echo_byte),
        .rd_byte(rd_byte)
    );
    isp_sync #(.W(2)) u_tgl_sync (
        .clk(clk),
        .d({frame_tgl, echo_tgl}),
        .q(tgl_q)
    );
    always_ff @(posedge clk) begin
        tgl_s <= {1'b0, tgl_q};
        tgl_d <= tgl_s;
    end
    assign frame_evt = tgl_s[1] ^ tgl_d[1];
    assign echo_evt = tgl_s[0] ^ tgl_d[0];
    assign ins = instr_t'(frame);

    // programming enable latch
    always_ff @(posedge clk) begin
        if (srst || !in_prog) begin
            prog_enabled <= 1'b0;
        end else if (frame_evt && ins.b1 == OP_PROG && ins.b2 == SUB_ENABLE) begin
            prog_enabled <= 1'b1;
        end
    end

    // extended address kept until reloaded
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_adr <= ZERO_BYTE;
        end else if (frame_evt && prog_enabled && ins.b1 == OP_LD_EXT) begin
            ext_adr <= ins.b3;
        end
    end

    // page buffers
    always_ff @(posedge clk) begin
        if (frame_evt && prog_enabled) begin
            if (ins.b1 == OP_LD_LO) begin
                buf_lo[ins.b3[PAGE_BITS-1:0]] <= ins.b4;
            end
            if (ins.b1 == OP_LD_HI) begin
                buf_hi[ins.b3[PAGE_BITS-1:0]] <= ins.b4;
            end
            if (ins.b1 == OP_LD_EE) begin
                ee_buf[ins.b3[EE_PG_BITS-1:0]] <= ins.b4;
            end
        end
    end

    // fuse and lock bytes, one means unprogrammed
    always_ff @(posedge clk) begin
        if (srst) begin
            fuses <= {ERASED, ERASED, ERASED, ERASED};
        end else if (frame_evt && prog_enabled && op == ST_IDLE && ins.b1 == OP_PROG) begin
            unique case (ins.b2)
                SUB_LOCK: fuses.lock <= ins.b4;
                SUB_FUSE_LO: fuses.fuse_lo <= ins.b4;
                SUB_FUSE_HI: fuses.fuse_hi <= ins.b4;
                SUB_FUSE_EXT: fuses.fuse_ext <= ins.b4;
                default: ;
            endcase
        end else if (op == ST_ERASE && erase_idx == '0) begin
            fuses.lock <= ERASED;
        end
    end

    // self-timed operations and busy flag
    always_ff @(posedge clk) begin
        if (srst) begin
            op <= ST_IDLE;
            wait_cnt <= '0;
            op_adr <= '0;
            ee_adr <= '0;
            ee_page <= 1'b0;
        end else if (op != ST_IDLE) begin
            if (wait_cnt == '0 && !erase_busy) begin
                op <= ST_IDLE;
            end else begin
                wait_cnt <= wait_cnt - 32'd1;
            end
        end else if (frame_evt && prog_enabled) begin
            if (ins.b1 == OP_PROG && ins.b2 == SUB_ERASE) begin
                op <= ST_ERASE;
                wait_cnt <= 32'(ERASE_WAIT - 1);
            end else if (ins.b1 == OP_WR_PAGE) begin
                op <= ST_FLASH;
                op_adr <= FLASH_AW'({ext_adr, ins.b2, ins.b3});
                wait_cnt <= 32'(FLASH_WAIT - 1);
            end else if (ins.b1 == OP_WR_EE || ins.b1 == OP_WR_EE_PG) begin
                op <= ST_EE;
                ee_adr <= EE_BITS'({ins.b2, ins.b3});
                ee_page <= (ins.b1 == OP_WR_EE_PG);
                wait_cnt <= 32'(EE_WAIT - 1);
            end
        end
    end
    assign pending_operation_flag = (op != ST_IDLE);
    assign erase_busy = (op == ST_ERASE) && !erase_idx[FLASH_AW];

    // array updates; eeprom target overwritten, so erased first
    always_ff @(posedge clk) begin
        if (srst || op == ST_IDLE) begin
            erase_idx <= '0;
            copy_idx <= '0;
        end else if (op == ST_ERASE) begin
            if (!erase_idx[FLASH_AW]) begin
                flash_lo[erase_idx[FLASH_AW-1:0]] <= ERASED;
                flash_hi[erase_idx[FLASH_AW-1:0]] <= ERASED;
                if (erase_idx < (FLASH_AW+1)'(1 << EE_BITS)) begin
                    eeprom[erase_idx[EE_BITS-1:0]] <= ERASED;
                end
                erase_idx <= erase_idx + 1'b1;
            end
        end else if (op == ST_FLASH && !copy_idx[PAGE_BITS]) begin
            flash_lo[{op_adr[FLASH_AW-1:PAGE_BITS], copy_idx[PAGE_BITS-1:0]}]
                <= buf_lo[copy_idx[PAGE_BITS-1:0]];
            flash_hi[{op_adr[FLASH_AW-1:PAGE_BITS], copy_idx[PAGE_BITS-1:0]}]
                <= buf_hi[copy_idx[PAGE_BITS-1:0]];
            copy_idx <= copy_idx + 1'b1;
        end else if (op == ST_EE && copy_idx == '0) begin
            if (ee_page) begin
                for (int i = 0; i < (1 << EE_PG_BITS); i++) begin
                    eeprom[{ee_adr[EE_BITS-1:EE_PG_BITS], EE_PG_BITS'(i)}] <= ee_buf[i];
                end
            end else begin
                eeprom[ee_adr] <= frame[7:0];
            end
            copy_idx <= copy_idx + 1'b1;
        end
    end

    // sck half period must span about four clk cycles for byte four to be ready
    // read data for byte four, staged once the first three bytes are
    logic [23:0] head;
    logic [FLASH_AW-1:0] rd_fadr;
    assign head = frame[23:0];
    assign rd_fadr = FLASH_AW'({ext_adr, head[15:0]});

    // signature byte by two-bit index
    function automatic logic [7:0] sig_byte(input logic [1:0] idx);
        unique case (idx)
            2'b00: sig_byte = SIG0;
            2'b01: sig_byte = SIG1;
            2'b10: sig_byte = SIG2;
            default: sig_byte = ERASED;
        endcase
    endfunction : sig_byte

    // second byte picks the high or extended byte
    function automatic logic [7:0] pick_byte(input logic [7:0] sel, input logic [7:0] base_v,
            input logic [7:0] alt_v);
        return (sel == SUB_HI_SEL) ? alt_v : base_v;
    endfunction : pick_byte

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_byte <= ZERO_BYTE;
        end else if (echo_evt) begin
            if (!prog_enabled) begin
                rd_byte <= ERASED;
            end else begin
                unique case (head[23:16])
                    OP_POLL: rd_byte <= {ZERO_BYTE[7:1], pending_operation_flag};
                    OP_RD_LO: rd_byte <= flash_lo[rd_fadr];
                    OP_RD_HI: rd_byte <= flash_hi[rd_fadr];
                    OP_RD_EE: rd_byte <= eeprom[EE_BITS'(head[15:0])];
                    OP_RD_LOCK: rd_byte <= pick_byte(head[15:8], fuses.lock, fuses.fuse_hi);
                    OP_RD_FUSE: rd_byte <= pick_byte(head[15:8], fuses.fuse_lo, fuses.fuse_ext);
                    OP_RD_SIG: rd_byte <= sig_byte(head[EE_PG_BITS-1:0]);
                    OP_RD_CAL: rd_byte <= CAL;
                    default: rd_byte <= ERASED;
                endcase
            end
        end
    end

    // checks
    default clocking cb_core @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_enable_frame;
        frame_evt && in_prog && ins.b1 == OP_PROG && ins.b2 == SUB_ENABLE;
    endsequence
    sequence s_ee_write;
        frame_evt && prog_enabled && op == ST_IDLE && ins.b1 == OP_WR_EE;
    endsequence
    sequence s_page_write;
        frame_evt && prog_enabled && op == ST_IDLE && ins.b1 == OP_WR_PAGE;
    endsequence
    sequence s_poll_head;
        echo_evt && prog_enabled && head[23:16] == OP_POLL;
    endsequence

    property p_enable_taken;
        s_enable_frame ##1 in_prog |-> prog_enabled;
    endproperty
    a_enable_taken: assert property (p_enable_taken)
        else $error("enable instruction not taken");

    property p_enable_dropped;
        !in_prog |=> !prog_enabled;
    endproperty
    a_enable_dropped: assert property (p_enable_dropped)
        else $error("enable kept outside programming mode");

    property p_op_needs_enable;
        $rose(pending_operation_flag) |-> $past(prog_enabled);
    endproperty
    a_op_needs_enable: assert property (p_op_needs_enable)
        else $error("operation started without enable");

    property p_locked_out;
        frame_evt && !prog_enabled && !pending_operation_flag |=> !pending_operation_flag;
    endproperty
    a_locked_out: assert property (p_locked_out)
        else $error("instruction accepted before enable");

    property p_ee_start;
        s_ee_write |=> op == ST_EE;
    endproperty
    a_ee_start: assert property (p_ee_start)
        else $error("eeprom write not started");

    property p_page_start;
        s_page_write |=> op == ST_FLASH;
    endproperty
    a_page_start: assert property (p_page_start)
        else $error("page write not started");

    property p_poll_lsb;
        s_poll_head |=> rd_byte[0] == $past(pending_operation_flag);
    endproperty
    a_poll_lsb: assert property (p_poll_lsb)
        else $error("poll byte does not show pending state");

    property p_ext_kept;
        !(frame_evt && prog_enabled && ins.b1 == OP_LD_EXT) |=> $stable(ext_adr);
    endproperty
    a_ext_kept: assert property (p_ext_kept)
        else $error("extended address changed without reload");

    property p_erase_lock;
        op == ST_ERASE && erase_idx == '0 |=> fuses.lock == ERASED;
    endproperty
    a_erase_lock: assert property (p_erase_lock)
        else $error("erase left lock byte programmed");
endmodule : isp_core

// [testbench/isp_programmer.sv]
// programmer model driving the serial link as master
`timescale 1ns/1ps
module isp_programmer (
    // link pins
    output logic sck,
    output logic mosi,
    output logic reset_n_pin,
    input wire logic miso
);
    logic base = 1'b0;
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        reset_n_pin = 1'b0;
        #1.3;
        forever #3 base = ~base;
    end
    task automatic half();
        repeat (8) @(posedge base);
    endtask : half
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            mosi = tx[i];
            half();
            sck = 1'b1;
            rx[i] = miso;
            half();
            sck = 1'b0;
        end
        half();
        mosi = ~tx[0];
    endtask : xfer
    task automatic pulse(input int ticks);
        reset_n_pin = 1'b1;
        repeat (ticks) @(posedge base);
        reset_n_pin = 1'b0;
        repeat (40) @(posedge base);
    endtask : pulse
endmodule : isp_programmer

// [testbench/tb_top.sv]
// self-checking bench for the serial programming slave
`timescale 1ns/1ps
module tb_top;
    import isp_pkg::*;
    localparam int FW = 400;
    localparam int EW = 800;
    localparam int CW = 1200;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sck;
    logic mosi;
    logic miso;
    logic reset_n_pin;
    logic prog_enabled;
    logic pending_operation_flag;
    fuses_t fuses;
    logic [31:0] rx;
    int errors = 0;
    int checked = 0;
    always #4 clk = ~clk;
    // signature and calibration values are arbitrary
    isp_core #(.FLASH_AW(10), .FLASH_WAIT(FW), .EE_WAIT(EW), .ERASE_WAIT(CW), .SIG0(8'h3C),
        .CAL(8'h6B)) dut (
        .clk(clk), .srst(srst), .reset_n_pin(reset_n_pin), .sck(sck),
        .mosi(mosi), .miso(miso), .prog_enabled(prog_enabled),
        .pending_operation_flag(pending_operation_flag), .fuses(fuses));
    isp_programmer prog (.sck(sck), .mosi(mosi), .reset_n_pin(reset_n_pin),
        .miso(miso));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic send(input logic [31:0] tx);
        prog.xfer(tx, rx);
        repeat (8) @(negedge clk);
    endtask : send
    task automatic rd(input logic [31:0] tx, input logic [7:0] exp);
        send(tx);
        check(32'(rx[7:0]), 32'(exp));
    endtask : rd
    task automatic busy_len(input int w);
        int n;
        n = 0;
        check(32'(pending_operation_flag), 32'h1);
        while (pending_operation_flag === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(32'(n > w - 30 && n <= w), 32'h1);
    endtask : busy_len
    task automatic t_locked();
        send(32'hACA00012);
        check(fuses, 32'hFFFFFFFF);
        send(32'hAC800000);
        check(32'(pending_operation_flag), 32'h0);
        check(32'(prog_enabled), 32'h0);
        $display("locked done");
    endtask : t_locked
    task automatic t_enable();
        prog.xfer(32'hAC530000, rx);
        check(32'(rx[15:8]), 32'h53);
        repeat (8) @(negedge clk);
        check(32'(prog_enabled), 32'h1);
        $display("enable done");
    endtask : t_enable
    task automatic t_fuses();
        logic [7:0] sub[4] = '{8'hE0, 8'hA0, 8'hA8, 8'hA4};
        logic [15:0] op[4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
        logic [7:0] v[4] = '{8'hFC, 8'hE2, 8'hD9, 8'hFE};
        for (int i = 0; i < 4; i++) begin
            send({8'hAC, sub[i], 8'h00, v[i]});
            check(32'(fuses[31-8*i -: 8]), 32'(v[i]));
            rd({op[i], 16'h0000}, v[i]);
        end
        rd(32'h30000000, 8'h3C);
        rd(32'h38000000, 8'h6B);
        $display("fuses done");
    endtask : t_fuses
    task automatic t_mem();
        send(32'h4D000000);
        send(32'h40000512);
        send(32'h48000534);
        send(32'h4C000500);
        busy_len(FW);
        rd(32'h20000500, 8'h12);
        rd(32'h28000500, 8'h34);
        send(32'hC00010AB);
        busy_len(EW);
        send(32'hC0001054);
        busy_len(EW);
        rd(32'hA0001000, 8'h54);
        send(32'hC10001CD);
        send(32'hC2000400);
        busy_len(EW);
        rd(32'hA0000500, 8'hCD);
        send(32'hAC800000);
        busy_len(CW);
        rd(32'h20000500, 8'hFF);
        rd(32'hA0001000, 8'hFF);
        $display("memory done");
    endtask : t_mem
    task automatic t_busy();
        int n;
        n = 0;
        send(32'hAC800000);
        send(32'hC0002000);
        send(32'hF0000000);
        check(32'(rx[0]), 32'h1);
        while (pending_operation_flag !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 3000), 32'h1);
        send(32'hF0000000);
        check(32'(rx[0]), 32'h0);
        rd(32'hA0002000, 8'hFF);
        $display("busy done");
    endtask : t_busy
    task automatic t_pin();
        prog.pulse(20);
        repeat (8) @(negedge clk);
        check(32'(prog_enabled), 32'h0);
        send(32'hACA00000);
        check(32'(fuses.fuse_lo), 32'hE2);
        $display("pin done");
    endtask : t_pin
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        repeat (40) @(negedge clk);
        check(fuses, 32'hFFFFFFFF);
        check(32'(pending_operation_flag), 32'h0);
        t_locked();
        t_enable();
        t_fuses();
        t_mem();
        t_busy();
        t_pin();
        t_enable();
        test_done();
    end
endmodule : tb_top
